// ==== core/edge_event_line_controller.v ====
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "line_ctrl_map.vh"

module edge_event_line_controller #(
   parameter NL = `NUM_LINES,                     // Number of lines
   parameter NG = `NUM_GPIO                       // Number of pins
) (
   input  wire          aclk,                     // Bus clock
   input  wire          aresetn,                  // Sync reset, low
   input  wire [NG-1:0] gpio_in,                  // General-purpose pins
   input  wire [NG-1:0] gpio_rise_pulse,          // Sub-cycle rising pulse seen
   input  wire [NG-1:0] gpio_fall_pulse,          // Sub-cycle falling pulse seen
   input  wire          supply_voltage_detector,  // Supply detector output
   input  wire          rtc_alarm,                // Real-time clock alarm
   input  wire          usb_full_speed_port,      // USB wakeup
   input  wire          spare_event,              // Fourth internal source
   input  wire [3:0]    s_axi_awaddr_hi,          // Unused upper four address bits
   input  wire [7:0]    s_axi_awaddr,             // Write address
   input  wire          s_axi_awvalid,            // Write address valid
   output wire          s_axi_awready,            // Write address ready
   input  wire [31:0]   s_axi_wdata,              // Write data
   input  wire [3:0]    s_axi_wstrb,              // Write strobes
   input  wire          s_axi_wvalid,             // Write data valid
   output wire          s_axi_wready,             // Write data ready
   output reg  [1:0]    s_axi_bresp,              // Write response
   output reg           s_axi_bvalid,             // Write response valid
   input  wire          s_axi_bready,             // Write response ready
   input  wire [7:0]    s_axi_araddr,             // Read address
   input  wire          s_axi_arvalid,            // Read address valid
   output wire          s_axi_arready,            // Read address ready
   output reg  [31:0]   s_axi_rdata,              // Read data
   output reg  [1:0]    s_axi_rresp,              // Read response
   output reg           s_axi_rvalid,             // Read valid
   input  wire          s_axi_rready,             // Read ready
   output wire          irq,                      // Level interrupt
   output reg  [NL-1:0] event_pulse,              // One-cycle event pulses
   output wire          wakeup                    // Any unmasked line pending or event
);

   // ==========================================
   // State
   reg  [NL-1:0]   mask_q;                        // Interrupt enable per line
   reg  [NL-1:0]   evmask_q;                      // Event enable per line
   reg  [NL-1:0]   rise_q;                        // Rising trigger select
   reg  [NL-1:0]   fall_q;                        // Falling trigger select
   reg  [NL-1:0]   pend_q;                        // Pending status
   reg  [NL-1:0]   lvl_q;                         // Previous line level
   reg  [6:0]      sel_q [0:15];                  // Pin selection per pin line
   reg  [7:0]      awaddr_q;                      // Latched write address
   reg             aw_have_q;                     // Write address held
   reg  [31:0]     wdata_q;                       // Latched write data
   reg  [3:0]      wstrb_q;                       // Latched strobes
   reg             w_have_q;                      // Write data held
   reg  [NL-1:0]   line_lvl;                      // Current line levels
   reg  [NL-1:0]   rp;                            // Rising pulse per line
   reg  [NL-1:0]   fp;                            // Falling pulse per line
   wire [NL-1:0]   trig;                          // Selected edge detected
   wire [NL-1:0]   sw_wr;                         // Software trigger bits
   wire [NL-1:0]   clr_wr;                        // Pending clear bits
   wire            do_wr;                         // Write commits this cycle
   wire [3:0]      widx;                          // Write register index
   wire [31:0]     wr_bits;                       // Strobed write data over zero
   wire [31:0]     mask_m;                        // Interrupt mask after merge
   wire [31:0]     evmask_m;                      // Event mask after merge
   wire [31:0]     rise_m;                        // Rising select after merge
   wire [31:0]     fall_m;                        // Falling select after merge
   integer         i;                             // Loop index, line sources
   integer         j;                             // Loop index, configuration

   // Strobe merge of a 32-bit write onto an old value
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  st;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            merge[k*8 +: 8] = st[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
         end
      end
   endfunction

   // Register index from byte address
   function [3:0] ridx;
      input [7:0] a;
      begin
         ridx = a[5:2];
      end
   endfunction

   // ==========================================
   // Line sources
   // Each pin line taps a selected pin; sub-cycle pulses come from pad latches
   always @* begin
      line_lvl = {NL{1'b0}};
      rp       = {NL{1'b0}};
      fp       = {NL{1'b0}};
      for (i = 0; i < `NUM_PIN_LINES; i = i + 1) begin
         line_lvl[i] = gpio_in[sel_q[i]];
         rp[i]       = gpio_rise_pulse[sel_q[i]];
         fp[i]       = gpio_fall_pulse[sel_q[i]];
      end
      line_lvl[`LINE_SVD] = supply_voltage_detector;
      line_lvl[`LINE_RTC] = rtc_alarm;
      line_lvl[`LINE_USB] = usb_full_speed_port;
      line_lvl[NL-1]      = spare_event;
   end

   // Edge qualification per line
   assign trig = (rise_q & (rp | (line_lvl & ~lvl_q)))
               | (fall_q & (fp | (~line_lvl & lvl_q)));

   // ==========================================
   // AXI4-Lite write path
   assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
   assign do_wr  = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign widx   = ridx(awaddr_q);
   // Merged words are full width; only the line bits are kept
   assign wr_bits  = merge(32'h00000000, wdata_q, wstrb_q);
   assign mask_m   = merge({{(32-NL){1'b0}}, mask_q}, wdata_q, wstrb_q);
   assign evmask_m = merge({{(32-NL){1'b0}}, evmask_q}, wdata_q, wstrb_q);
   assign rise_m   = merge({{(32-NL){1'b0}}, rise_q}, wdata_q, wstrb_q);
   assign fall_m   = merge({{(32-NL){1'b0}}, fall_q}, wdata_q, wstrb_q);
   assign sw_wr  = (do_wr && awaddr_q[7:2] == {2'b00, `OFS_SWTRIG}) ?
                   wr_bits[NL-1:0] : {NL{1'b0}};
   assign clr_wr = (do_wr && awaddr_q[7:2] == {2'b00, `OFS_PEND}) ?
                   wr_bits[NL-1:0] : {NL{1'b0}};

   // Address/data capture, in either order, then response
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         awaddr_q     <= 8'h00;
         wdata_q      <= 32'h00000000;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q[7:6] == 2'b00 && widx <= `OFS_PINSEL3) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Configuration registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         mask_q   <= `RST_MASK;
         evmask_q <= `RST_MASK;
         rise_q   <= `RST_RISE;
         fall_q   <= `RST_FALL;
         for (j = 0; j < 16; j = j + 1) begin
            sel_q[j] <= 7'h00;
         end
      end else if (do_wr && awaddr_q[7:6] == 2'b00) begin
         case (widx)
            `OFS_MASK:   mask_q   <= mask_m[NL-1:0];
            `OFS_EVMASK: evmask_q <= evmask_m[NL-1:0];
            `OFS_RISE:   rise_q   <= rise_m[NL-1:0];
            `OFS_FALL:   fall_q   <= fall_m[NL-1:0];
            `OFS_PINSEL0, `OFS_PINSEL1, `OFS_PINSEL2, `OFS_PINSEL3: begin
               for (j = 0; j < 4; j = j + 1) begin
                  if (wstrb_q[j]) begin
                     // Out-of-range selection saturates to the last pin
                     sel_q[(widx - `OFS_PINSEL0) * 4 + j] <=
                        (wdata_q[j*8 +: 7] < NG) ? wdata_q[j*8 +: 7] : 7'h4F;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // ==========================================
   // Detection, pending and events
   // Set wins over a same-cycle software clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         pend_q      <= {NL{1'b0}};
         lvl_q       <= {NL{1'b0}};
         event_pulse <= {NL{1'b0}};
      end else begin
         lvl_q       <= line_lvl;
         pend_q      <= (pend_q & ~clr_wr) | ((trig | sw_wr) & mask_q);
         event_pulse <= (trig | sw_wr) & evmask_q;
      end
   end

   assign irq    = |(pend_q & mask_q);
   assign wakeup = irq | (|event_pulse);

   // ==========================================
   // AXI4-Lite read path
   assign s_axi_arready = ~s_axi_rvalid;

   // Read mux with registered data
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
         if (s_axi_araddr[7:6] != 2'b00) begin
            s_axi_rresp <= `RESP_SLVERR;
         end else begin
            case (ridx(s_axi_araddr))
               `OFS_MASK:    s_axi_rdata <= {12'h000, mask_q};
               `OFS_EVMASK:  s_axi_rdata <= {12'h000, evmask_q};
               `OFS_RISE:    s_axi_rdata <= {12'h000, rise_q};
               `OFS_FALL:    s_axi_rdata <= {12'h000, fall_q};
               `OFS_SWTRIG:  s_axi_rdata <= 32'h00000000;
               `OFS_PEND:    s_axi_rdata <= {12'h000, pend_q};
               `OFS_PINSEL0: s_axi_rdata <= {1'b0, sel_q[3], 1'b0, sel_q[2], 1'b0, sel_q[1], 1'b0, sel_q[0]};
               `OFS_PINSEL1: s_axi_rdata <= {1'b0, sel_q[7], 1'b0, sel_q[6], 1'b0, sel_q[5], 1'b0, sel_q[4]};
               `OFS_PINSEL2: s_axi_rdata <= {1'b0, sel_q[11], 1'b0, sel_q[10], 1'b0, sel_q[9], 1'b0, sel_q[8]};
               `OFS_PINSEL3: s_axi_rdata <= {1'b0, sel_q[15], 1'b0, sel_q[14], 1'b0, sel_q[13], 1'b0, sel_q[12]};
               default:      s_axi_rresp <= `RESP_SLVERR;
            endcase
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // edge_event_line_controller

// ==== core/line_ctrl_map.vh ====
`ifndef LINE_CTRL_MAP_VH
`define LINE_CTRL_MAP_VH
// ==========================================
// Register offsets (word indices; byte address is four times the index)
`define OFS_MASK      4'h0
`define OFS_EVMASK    4'h1
`define OFS_RISE      4'h2
`define OFS_FALL      4'h3
`define OFS_SWTRIG    4'h4
`define OFS_PEND      4'h5
`define OFS_PINSEL0   4'h6
`define OFS_PINSEL1   4'h7
`define OFS_PINSEL2   4'h8
`define OFS_PINSEL3   4'h9
// ==========================================
// Reset values
`define RST_MASK      20'h00000
`define RST_RISE      20'h00000
`define RST_FALL      20'h00000
`define RST_PINSEL    32'h00000000
// ==========================================
// Line layout
`define NUM_LINES     20
`define NUM_PIN_LINES 16
`define NUM_GPIO      80
`define LINE_SVD      16
`define LINE_RTC      17
`define LINE_USB      18
// AXI response codes
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// ==== tb/line_ctrl_props.sv ====
`timescale 1ns/1ns
`include "line_ctrl_map.vh"
// ==========================================
// Port-level checks of the line controller
module line_ctrl_props #(parameter NL = 20) (
   input logic          aclk,          // Clock
   input logic          aresetn,       // Sync reset, low
   input logic [7:0]    s_axi_awaddr,  // Write address
   input logic          s_axi_awvalid, // Write address valid
   input logic          s_axi_awready, // Write address ready
   input logic [31:0]   s_axi_wdata,   // Write data
   input logic [3:0]    s_axi_wstrb,   // Write strobes
   input logic          s_axi_wvalid,  // Write data valid
   input logic          s_axi_wready,  // Write data ready
   input logic          s_axi_bvalid,  // Write response valid
   input logic          s_axi_bready,  // Write response ready
   input logic [7:0]    s_axi_araddr,  // Read address
   input logic          s_axi_arvalid, // Read address valid
   input logic          s_axi_arready, // Read address ready
   input logic [31:0]   s_axi_rdata,   // Read data
   input logic [1:0]    s_axi_rresp,   // Read response
   input logic          s_axi_rvalid,  // Read valid
   input logic          s_axi_rready,  // Read ready
   input logic          irq,           // Level interrupt
   input logic [NL-1:0] event_pulse,   // Event pulses
   input logic          wakeup         // Wakeup request
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_wake; wakeup == (irq || (|event_pulse)); endproperty
   a_wake: assert property (p_wake) else $error("wakeup not irq or event");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer not held");
   property p_arblk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arblk: assert property (p_arblk) else $error("arready while rvalid");
   property p_awblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_awblk: assert property (p_awblk) else $error("write taken while bvalid");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("rvalid late");
   property p_blat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
   a_blat: assert property (p_blat) else $error("bvalid late");
   property p_bad; s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h27 |=>
      s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
   a_bad: assert property (p_bad) else $error("unmapped read not refused");
   property p_mask; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h00
      && s_axi_wdata[19:0] == 20'h0 && s_axi_wstrb == 4'hF |-> ##2 !irq; endproperty
   a_mask: assert property (p_mask) else $error("irq with all lines masked");
endmodule // line_ctrl_props
bind edge_event_line_controller line_ctrl_props #(.NL(NL)) i_props (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .irq(irq), .event_pulse(event_pulse), .wakeup(wakeup));

// ==== tb/pin_source.sv ====
`timescale 1ns/1ns
// ==========================================
// Pins and internal event sources feeding the lines
module pin_source (
   input  logic        aclk,       // Clock
   output logic [79:0] gpio_in,    // Pin levels
   output logic [79:0] rise_pulse, // Short rising pulse seen
   output logic [79:0] fall_pulse, // Short falling pulse seen
   output logic [3:0]  internal    // Detector, alarm, USB, spare
);
   logic [83:0] lvl_q = 84'h0; // Levels, pins then internal sources
   assign gpio_in = lvl_q[79:0];
   assign internal = lvl_q[83:80];
   initial rise_pulse = 80'h0;
   initial fall_pulse = 80'h0;
   // Change one level just after an edge
   task set_level(input int i, input logic v);
      @(posedge aclk);
      lvl_q[i] <= v;
   endtask
   // Pad latch report of a pulse narrower than a clock
   task short_pulse(input int i, input logic up);
      @(posedge aclk);
      if (up) rise_pulse[i] <= 1'b1;
      else fall_pulse[i] <= 1'b1;
      @(posedge aclk);
      rise_pulse <= 80'h0;
      fall_pulse <= 80'h0;
   endtask
endmodule // pin_source

// ==== tb/edge_event_line_controller_test.sv ====
`timescale 1ns/1ns
// ==========================================
// Bench top
module edge_event_line_controller_test;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   wire         awready, wready, bvalid, arready, rvalid, irq, wakeup;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [19:0]  event_pulse;
   wire [79:0]  gpio_in, rise_p, fall_p;
   wire [3:0]   src;
   int          bad_count = 0, tests_run = 0, ev_cnt = 0;
   always #5 aclk = ~aclk;
   always @(posedge aclk) if (event_pulse[17]) ev_cnt <= ev_cnt + 1;
   pin_source i_src (.aclk(aclk), .gpio_in(gpio_in), .rise_pulse(rise_p), .fall_pulse(fall_p), .internal(src));
   edge_event_line_controller i_dut (.aclk(aclk), .aresetn(aresetn), .gpio_in(gpio_in), .gpio_rise_pulse(rise_p),
      .gpio_fall_pulse(fall_p), .supply_voltage_detector(src[0]), .rtc_alarm(src[1]), .usb_full_speed_port(src[2]),
      .spare_event(src[3]), .s_axi_awaddr_hi(4'h0), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .event_pulse(event_pulse),
      .wakeup(wakeup));
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   // Bus write: address and data offered together, each released when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic da, dw;
      logic [1:0] br;
      da = 0;
      dw = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(da && dw)) begin
         @(negedge aclk);
         if (awready) da = 1;
         if (wready) dw = 1;
         @(posedge aclk);
         if (da) awvalid <= 0;
         if (dw) wvalid <= 0;
      end
      do @(negedge aclk); while (!bvalid);
      br = bresp;
      @(posedge aclk);
      bready <= 0;
      chk("bresp", (a < 8'h28) ? 32'h0 : 32'h2, {30'h0, br});
   endtask
   // Bus read with expected data and response
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] got;
      logic [1:0] gr;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 0;
      do @(negedge aclk); while (!rvalid);
      got = rdata;
      gr = rresp;
      @(posedge aclk);
      rready <= 0;
      chk("rdata", e, got);
      chk("rresp", {30'h0, er}, {30'h0, gr});
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      bad_count++;
      give_verdict;
   end
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      for (int a = 0; a < 40; a += 4) rd(8'(a), 32'h0, 2'h0);
      rd(8'h28, 32'h0, 2'h2);
      wr(8'h00, 32'h000FFFFF);
      for (int m = 1; m < 4; m++) begin
         wr(8'h08, 32'(m & 1));
         wr(8'h0C, 32'(m >> 1));
         i_src.set_level(0, 1'b1);
         rd(8'h14, 32'(m & 1), 2'h0);
         chk("irq", 32'(m & 1), {31'h0, irq});
         wr(8'h14, 32'h1);
         i_src.set_level(0, 1'b0);
         rd(8'h14, 32'(m >> 1), 2'h0);
         wr(8'h14, 32'h1);
         rd(8'h14, 32'h0, 2'h0);
      end
      wr(8'h18, 32'h00000500);
      wr(8'h24, 32'h4F000000);
      wr(8'h08, 32'h00008000);
      wr(8'h0C, 32'h00000002);
      i_src.short_pulse(5, 1'b0);
      i_src.short_pulse(79, 1'b1);
      rd(8'h14, 32'h00008002, 2'h0);
      wr(8'h00, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      rd(8'h14, 32'h00008002, 2'h0);
      wr(8'h14, 32'h00008002);
      i_src.short_pulse(5, 1'b0);
      rd(8'h14, 32'h0, 2'h0);
      wr(8'h00, 32'h00020000);
      wr(8'h04, 32'h00020000);
      wr(8'h08, 32'h00020000);
      wr(8'h40, 32'h00000001);
      rd(8'h00, 32'h00020000, 2'h0);
      i_src.set_level(81, 1'b1);
      rd(8'h14, 32'h00020000, 2'h0);
      chk("irq", 32'h1, {31'h0, irq});
      chk("wakeup", 32'h1, {31'h0, wakeup});
      chk("events", 32'h1, 32'(ev_cnt));
      wr(8'h14, 32'h00020000);
      chk("wakeup", 32'h0, {31'h0, wakeup});
      wr(8'h10, 32'h00020000);
      rd(8'h14, 32'h00020000, 2'h0);
      chk("events", 32'h2, 32'(ev_cnt));
      give_verdict;
   end
endmodule // edge_event_line_controller_test
